//--- hw/scs_sequencer.sv
// Synthesizer calibration and settling sequencer with its register bank.
// Assumes commands and register strobes are synchronous one-cycle pulses.
//
// Operation
// - Transmit or receive command starts VCO calibration, or skips it when bypass is armed.
// - Calibration lasts exactly 142 us.
// - Status register shows calibration completion.
// - Default settling wait is 56 us.
// - Custom enable bit selects programmed settling delays.
// - Separate receive and transmit custom delays applied.
// - Custom delay 2 to 512 us, 2 us steps.
// - Loop bandwidth chosen on each state entry.
// - Receive always uses the 92 kHz bandwidth.
// - FSK transmit bandwidth follows data rate table.
// - OOK transmit always uses 185 kHz.
// - Gaussian shaping enabled by modulation config.
// - VCO divider is two or four.
// - Band and amplitude results held for readback.
`timescale 1ns/100ps
`default_nettype none
module scs_sequencer #(
    parameter int unsigned CAL_CYCLES    = scs_pkg::CAL_CYCLES,
    parameter int unsigned SETTLE_CYCLES = scs_pkg::SETTLE_CYCLES
) (
    input  wire logic        clk_sys_i,          // System clock
    input  wire logic        reset_n_i,          // Async reset, active low
    input  wire logic        cmd_enter_receive_i,  // Receive command pulse
    input  wire logic        cmd_enter_transmit_i, // Transmit command pulse
    input  wire logic [11:0] data_rate_i,        // Data rate, 100 bps units
    input  wire logic        rf_band_low_i,      // Low RF band selected
    input  wire logic [7:0]  vco_band_cal_i,     // Calibrator band value
    input  wire logic [7:0]  vco_ampl_cal_i,     // Calibrator amplitude value
    input  wire logic [9:0]  reg_addr_i,         // Register address
    input  wire logic        reg_wr_i,           // Write strobe
    input  wire logic [7:0]  reg_wdata_i,        // Write data
    output logic      [7:0]  reg_rdata_o,        // Read data
    output logic             cal_run_o,          // Calibrator running
    output logic             synth_ready_o,      // Settled, state active
    output logic             receive_state_o,    // In receive state
    output logic             transmit_state_o,   // In transmit state
    output logic      [2:0]  loop_bw_sel_o,      // Loop bandwidth code
    output logic             gaussian_en_o,      // Gaussian shaping on
    output logic             vco_div4_o,         // VCO divide by four
    output logic      [7:0]  vco_band_o,         // Band applied to VCO
    output logic      [7:0]  vco_ampl_o          // Amplitude applied to VCO
);
    // ==========================================================
    // Reset release
    // ==========================================================
    logic [1:0] rst_sync;                 // Release synchroniser
    logic       rst_n;                    // Internal reset
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ==========================================================
    // Functions
    // ==========================================================
    // Pick loop bandwidth for a state entry
    function automatic logic [2:0] bw_select(input logic rx, input logic [1:0] md,
                                             input logic [11:0] rate);
        if (rx)
            bw_select = scs_pkg::BW_RX_92;
        else if (md == scs_pkg::MOD_OOK)
            bw_select = scs_pkg::BW_OOK_185;
        else if (rate <= scs_pkg::RATE_49K5)
            bw_select = scs_pkg::BW_TX_130;
        else if (rate <= scs_pkg::RATE_99K1)
            bw_select = scs_pkg::BW_TX_174_LO;
        else if (rate <= scs_pkg::RATE_129K5)
            bw_select = scs_pkg::BW_TX_174_HI;
        else if (rate <= scs_pkg::RATE_179K1)
            bw_select = scs_pkg::BW_TX_226;
        else if (rate <= scs_pkg::RATE_239K9)
            bw_select = scs_pkg::BW_TX_305;
        else
            bw_select = scs_pkg::BW_TX_382;
    endfunction
    // Custom delay code to cycles: (code + 1) steps of 2 us
    function automatic logic [15:0] custom_cycles(input logic [7:0] code);
        custom_cycles = 16'(({8'h00, code} + 16'h0001) * scs_pkg::STEP_CYCLES);
    endfunction

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] mod_cfg;                  // Modulation config
    logic [7:0] mode_ctrl;                // Mode control
    logic [7:0] rx_settle_delay;          // Receive custom delay
    logic [7:0] tx_settle_delay;          // Transmit custom delay
    logic [7:0] cal_ctrl;                 // Calibration control
    logic [7:0] vco_band_override;        // Stored band value
    logic [7:0] vco_amplitude_override;   // Stored amplitude value
    logic [7:0] vco_override_enable;      // Override enable
    logic [7:0] vco_cal_setup;            // Calibration setup
    logic [7:0] vco_band_result;          // Calibrated band
    logic [7:0] vco_amplitude_result;     // Calibrated amplitude
    logic       cal_done;                 // Status: calibration complete
    logic       settled;                  // Status: synthesizer settled
    logic       bypass_armed;             // Enable toggled 0 to 1
    logic       wr_cal_ctrl;              // Write to cal control
    logic       cmd_any;                  // Either state command
    logic       bypass;                   // Override conditions met

    assign wr_cal_ctrl = reg_wr_i && (reg_addr_i == scs_pkg::ADDR_CAL_CTRL);
    assign cmd_any     = cmd_enter_receive_i || cmd_enter_transmit_i;
    assign bypass      = bypass_armed &&
                         (vco_override_enable == scs_pkg::OVR_EN_BYPASS) &&
                         (vco_cal_setup == scs_pkg::CAL_SETUP_BYPASS);

    // Host writable registers
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mod_cfg                <= scs_pkg::REG_RESET;
            mode_ctrl              <= scs_pkg::REG_RESET;
            rx_settle_delay        <= scs_pkg::REG_RESET;
            tx_settle_delay        <= scs_pkg::REG_RESET;
            cal_ctrl               <= scs_pkg::REG_RESET;
            vco_band_override      <= scs_pkg::REG_RESET;
            vco_amplitude_override <= scs_pkg::REG_RESET;
            vco_override_enable    <= scs_pkg::REG_RESET;
            vco_cal_setup          <= scs_pkg::REG_RESET;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                scs_pkg::ADDR_MOD_CFG:   mod_cfg                <= reg_wdata_i;
                scs_pkg::ADDR_MODE_CTRL: mode_ctrl              <= reg_wdata_i;
                scs_pkg::ADDR_RX_SETTLE: rx_settle_delay        <= reg_wdata_i;
                scs_pkg::ADDR_TX_SETTLE: tx_settle_delay        <= reg_wdata_i;
                scs_pkg::ADDR_CAL_CTRL:  cal_ctrl               <= reg_wdata_i;
                scs_pkg::ADDR_BAND_OVR:  vco_band_override      <= reg_wdata_i;
                scs_pkg::ADDR_AMPL_OVR:  vco_amplitude_override <= reg_wdata_i;
                scs_pkg::ADDR_OVR_EN:    vco_override_enable    <= reg_wdata_i;
                scs_pkg::ADDR_CAL_SETUP: vco_cal_setup          <= reg_wdata_i;
                default:                 ;  // Read-only or unmapped
            endcase
        end
    end

    // Bypass arms on a 0 to 1 write of the enable, drops with override off
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            bypass_armed <= 1'b0;
        else if (vco_override_enable != scs_pkg::OVR_EN_BYPASS)
            bypass_armed <= 1'b0;
        else if (wr_cal_ctrl && !cal_ctrl[scs_pkg::CAL_ENABLE_BIT] &&
                 reg_wdata_i[scs_pkg::CAL_ENABLE_BIT])
            bypass_armed <= 1'b1;
    end

    // Read mux, unmapped reads as zero
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_o <= 8'h00;
        else
        begin
            case (reg_addr_i)
                scs_pkg::ADDR_MOD_CFG:     reg_rdata_o <= mod_cfg;
                scs_pkg::ADDR_MODE_CTRL:   reg_rdata_o <= mode_ctrl;
                scs_pkg::ADDR_RX_SETTLE:   reg_rdata_o <= rx_settle_delay;
                scs_pkg::ADDR_TX_SETTLE:   reg_rdata_o <= tx_settle_delay;
                scs_pkg::ADDR_CAL_CTRL:    reg_rdata_o <= cal_ctrl;
                scs_pkg::ADDR_CAL_STATUS:  reg_rdata_o <= {6'h00, settled, cal_done};
                scs_pkg::ADDR_BAND_OVR:    reg_rdata_o <= vco_band_override;
                scs_pkg::ADDR_AMPL_OVR:    reg_rdata_o <= vco_amplitude_override;
                scs_pkg::ADDR_OVR_EN:      reg_rdata_o <= vco_override_enable;
                scs_pkg::ADDR_CAL_SETUP:   reg_rdata_o <= vco_cal_setup;
                scs_pkg::ADDR_BAND_RESULT: reg_rdata_o <= vco_band_result;
                scs_pkg::ADDR_AMPL_RESULT: reg_rdata_o <= vco_amplitude_result;
                default:                   reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    scs_pkg::scs_state_t state;           // Current phase
    logic [15:0]         timer;           // Phase cycle counter
    logic [15:0]         settle_len;      // Settling length for this entry
    logic                entry_rx;        // Entry is to receive
    logic [15:0]         next_settle_len; // Settling length at command
    logic                cal_end;         // Last calibration cycle
    logic                settle_end;      // Last settling cycle

    assign cal_end    = (state == scs_pkg::ST_CAL) && (timer == 16'(CAL_CYCLES - 1));
    assign settle_end = (state == scs_pkg::ST_SETTLE) && (timer == settle_len - 16'h0001);

    // Settling length for the requested entry
    always_comb
    begin
        if (!mode_ctrl[scs_pkg::CUSTOM_SETTLE_BIT])
            next_settle_len = 16'(SETTLE_CYCLES);
        else if (cmd_enter_receive_i)
            next_settle_len = custom_cycles(rx_settle_delay);
        else
            next_settle_len = custom_cycles(tx_settle_delay);
    end

    // Phase state and counter; a new command restarts the sequence
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= scs_pkg::ST_IDLE;
            timer      <= 16'h0000;
            settle_len <= 16'h0001;
            entry_rx   <= 1'b0;
        end
        else if (cmd_any)
        begin
            timer      <= 16'h0000;
            settle_len <= next_settle_len;
            entry_rx   <= cmd_enter_receive_i;
            state      <= bypass ? scs_pkg::ST_SETTLE : scs_pkg::ST_CAL;
        end
        else
        begin
            case (state)
                scs_pkg::ST_CAL:
                begin
                    timer <= cal_end ? 16'h0000 : timer + 16'h0001;
                    if (cal_end)
                        state <= scs_pkg::ST_SETTLE;
                end
                scs_pkg::ST_SETTLE:
                begin
                    timer <= timer + 16'h0001;
                    if (settle_end)
                        state <= scs_pkg::ST_ACTIVE;
                end
                scs_pkg::ST_IDLE:   timer <= 16'h0000;
                scs_pkg::ST_ACTIVE: timer <= 16'h0000;
                default:            state <= scs_pkg::ST_IDLE;
            endcase
        end
    end

    // Status flags: cleared by a new command, set at phase end
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_done <= 1'b0;
            settled  <= 1'b0;
        end
        else
        begin
            if (cal_end)
                cal_done <= 1'b1;
            else if (cmd_any)
                cal_done <= 1'b0;
            if (settle_end)
                settled <= 1'b1;
            else if (cmd_any)
                settled <= 1'b0;
        end
    end

    // Calibration results captured at the end of calibration
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vco_band_result      <= 8'h00;
            vco_amplitude_result <= 8'h00;
        end
        else if (cal_end)
        begin
            vco_band_result      <= vco_band_cal_i;
            vco_amplitude_result <= vco_ampl_cal_i;
        end
    end

    // Bandwidth and divider latched at each entry; VCO drive at a bypass entry or at calibration end
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vco_band_o    <= 8'h00;
            vco_ampl_o    <= 8'h00;
            loop_bw_sel_o <= scs_pkg::BW_RX_92;
            vco_div4_o    <= 1'b0;
        end
        else if (cmd_any)
        begin
            loop_bw_sel_o <= bw_select(cmd_enter_receive_i,
                                       mod_cfg[scs_pkg::MOD_LSB +: 2],
                                       data_rate_i);
            vco_div4_o    <= rf_band_low_i;
            if (bypass)
            begin
                vco_band_o <= vco_band_override;
                vco_ampl_o <= vco_amplitude_override;
            end
        end
        else if (cal_end)
        begin
            vco_band_o <= vco_band_cal_i;
            vco_ampl_o <= vco_ampl_cal_i;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign cal_run_o        = (state == scs_pkg::ST_CAL);
    assign synth_ready_o    = (state == scs_pkg::ST_ACTIVE);
    assign receive_state_o  = (state != scs_pkg::ST_IDLE) && entry_rx;
    assign transmit_state_o = (state != scs_pkg::ST_IDLE) && !entry_rx;
    assign gaussian_en_o    = (mod_cfg[scs_pkg::MOD_LSB +: 2] == scs_pkg::MOD_GFSK);

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_cal_start;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (cmd_any && !bypass) |=> (state == scs_pkg::ST_CAL) && (timer == 16'h0000);
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("no calibration on command");
    property p_bypass;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (cmd_any && bypass) |=> (state == scs_pkg::ST_SETTLE) && (vco_band_o == $past(vco_band_override));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not skip calibration");
    property p_cal_len;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (state == scs_pkg::ST_CAL) && !$past(cmd_any) && $past(state) == scs_pkg::ST_CAL
            |-> $past(timer) < 16'(CAL_CYCLES - 1) && timer == $past(timer) + 16'h0001;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_status;
        @(posedge clk_sys_i) disable iff (!rst_n)
        cal_end && !cmd_any |=> cal_done && (state == scs_pkg::ST_SETTLE);
    endproperty
    a_status: assert property (p_status) else $error("calibration done not flagged");
    property p_default_settle;
        @(posedge clk_sys_i) disable iff (!rst_n)
        cmd_any && !mode_ctrl[scs_pkg::CUSTOM_SETTLE_BIT] |=> settle_len == 16'(SETTLE_CYCLES);
    endproperty
    a_default_settle: assert property (p_default_settle) else $error("default settle wrong");
    property p_custom_rx;
        @(posedge clk_sys_i) disable iff (!rst_n)
        cmd_enter_receive_i && mode_ctrl[scs_pkg::CUSTOM_SETTLE_BIT]
            |=> settle_len == 16'(($past(rx_settle_delay) + 1) * scs_pkg::STEP_CYCLES);
    endproperty
    a_custom_rx: assert property (p_custom_rx) else $error("receive custom settle wrong");
    property p_custom_tx;
        @(posedge clk_sys_i) disable iff (!rst_n)
        cmd_enter_transmit_i && !cmd_enter_receive_i && mode_ctrl[scs_pkg::CUSTOM_SETTLE_BIT]
            |=> settle_len == 16'(($past(tx_settle_delay) + 1) * scs_pkg::STEP_CYCLES);
    endproperty
    a_custom_tx: assert property (p_custom_tx) else $error("transmit custom settle wrong");
    property p_rx_bw;
        @(posedge clk_sys_i) disable iff (!rst_n)
        cmd_enter_receive_i |=> loop_bw_sel_o == scs_pkg::BW_RX_92;
    endproperty
    a_rx_bw: assert property (p_rx_bw) else $error("receive bandwidth wrong");
    property p_ook_bw;
        @(posedge clk_sys_i) disable iff (!rst_n)
        cmd_enter_transmit_i && !cmd_enter_receive_i && mod_cfg[1:0] == scs_pkg::MOD_OOK
            |=> loop_bw_sel_o == scs_pkg::BW_OOK_185;
    endproperty
    a_ook_bw: assert property (p_ook_bw) else $error("OOK bandwidth wrong");
    property p_fsk_low_bw;
        @(posedge clk_sys_i) disable iff (!rst_n)
        cmd_enter_transmit_i && !cmd_enter_receive_i && mod_cfg[1:0] != scs_pkg::MOD_OOK
            && data_rate_i <= scs_pkg::RATE_49K5 |=> loop_bw_sel_o == scs_pkg::BW_TX_130;
    endproperty
    a_fsk_low_bw: assert property (p_fsk_low_bw) else $error("low rate bandwidth wrong");
    c_cal_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n) cal_end);
    c_ready: cover property (@(posedge clk_sys_i) disable iff (!rst_n) settle_end);
    c_bypass: cover property (@(posedge clk_sys_i) disable iff (!rst_n) cmd_any && bypass);
endmodule : scs_sequencer
`default_nettype wire

//--- hw/scs_pkg.sv
// Constants shared by the synthesizer calibration and settling sequencer.
// Assumes a 125 MHz system clock and byte-wide register access.
package scs_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_MHZ          = 125;   // System clock rate
    localparam int unsigned CAL_TIME_US      = 142;   // VCO self-calibration
    localparam int unsigned SETTLE_TIME_US   = 56;    // Default settling
    localparam int unsigned STEP_TIME_US     = 2;     // Custom delay step
    localparam int unsigned CAL_CYCLES       = CAL_TIME_US * CLK_MHZ;
    localparam int unsigned SETTLE_CYCLES    = SETTLE_TIME_US * CLK_MHZ;
    localparam logic [15:0] STEP_CYCLES      = 16'(STEP_TIME_US * CLK_MHZ);
    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [9:0] ADDR_MOD_CFG      = 10'h115;
    localparam logic [9:0] ADDR_MODE_CTRL    = 10'h11A;
    localparam logic [9:0] ADDR_RX_SETTLE    = 10'h13E;
    localparam logic [9:0] ADDR_TX_SETTLE    = 10'h13F;
    localparam logic [9:0] ADDR_CAL_CTRL     = 10'h338;
    localparam logic [9:0] ADDR_CAL_STATUS   = 10'h339;
    localparam logic [9:0] ADDR_BAND_OVR     = 10'h3CB;
    localparam logic [9:0] ADDR_AMPL_OVR     = 10'h3CC;
    localparam logic [9:0] ADDR_OVR_EN       = 10'h3CD;
    localparam logic [9:0] ADDR_CAL_SETUP    = 10'h3D0;
    localparam logic [9:0] ADDR_BAND_RESULT  = 10'h3DA;
    localparam logic [9:0] ADDR_AMPL_RESULT  = 10'h3DB;
    // ==========================================================
    // Fields and values
    // ==========================================================
    localparam int unsigned MOD_LSB          = 0;     // Modulation [1:0]
    localparam logic [1:0]  MOD_FSK          = 2'h0;
    localparam logic [1:0]  MOD_GFSK         = 2'h1;
    localparam logic [1:0]  MOD_OOK          = 2'h2;
    localparam int unsigned CUSTOM_SETTLE_BIT = 3;    // In mode control
    localparam int unsigned CAL_ENABLE_BIT   = 0;     // In cal control
    localparam int unsigned ST_CAL_DONE_BIT  = 0;     // In cal status
    localparam int unsigned ST_SETTLED_BIT   = 1;     // In cal status
    localparam logic [7:0]  OVR_EN_BYPASS    = 8'h03;
    localparam logic [7:0]  CAL_SETUP_BYPASS = 8'h0F;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    // Data rate thresholds in units of 100 bps
    localparam logic [11:0] RATE_49K5        = 12'h1EF;  // 495
    localparam logic [11:0] RATE_99K1        = 12'h3DF;  // 991
    localparam logic [11:0] RATE_129K5       = 12'h50F;  // 1295
    localparam logic [11:0] RATE_179K1       = 12'h6FF;  // 1791
    localparam logic [11:0] RATE_239K9       = 12'h95F;  // 2399
    // Loop bandwidth configuration codes
    localparam logic [2:0]  BW_RX_92         = 3'h0;
    localparam logic [2:0]  BW_TX_130        = 3'h1;
    localparam logic [2:0]  BW_TX_174_LO     = 3'h2;
    localparam logic [2:0]  BW_TX_174_HI     = 3'h3;
    localparam logic [2:0]  BW_TX_226        = 3'h4;
    localparam logic [2:0]  BW_TX_305        = 3'h5;
    localparam logic [2:0]  BW_TX_382        = 3'h6;
    localparam logic [2:0]  BW_OOK_185       = 3'h7;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_CAL    = 4'b0010,
        ST_SETTLE = 4'b0100,
        ST_ACTIVE = 4'b1000
    } scs_state_t;
endpackage : scs_pkg

//--- test/scs_host.sv
// Host processor model: reaches the block's registers byte by byte.
// Assumes the bench calls its tasks and shares the system clock.
`timescale 1ns/100ps
`default_nettype none
module scs_host (
    input  wire logic       clk_sys_i,   // System clock
    input  wire logic [7:0] reg_rdata_i, // Read data
    output logic      [9:0] reg_addr_o,  // Address
    output logic            reg_wr_o,    // Write strobe
    output logic      [7:0] reg_wdata_o  // Write data
);
    initial {reg_addr_o, reg_wr_o, reg_wdata_o} = 19'h0_0000;
    // One write, held across one rising edge
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_sys_i) {reg_addr_o, reg_wr_o, reg_wdata_o} = {a, 1'b1, d};
        @(negedge clk_sys_i) {reg_wr_o, reg_wdata_o} = {1'b0, ~d};
    endtask
    // Read data answers one cycle after the address
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk_sys_i) reg_addr_o = a;
        @(negedge clk_sys_i) d = reg_rdata_i;
    endtask
    // Arm bypass with the stored band and amplitude
    task automatic arm(input logic [7:0] b, input logic [7:0] m);
        wr(10'h3CD, 8'h03);
        wr(10'h3D0, 8'h0F);
        wr(10'h3CB, b);
        wr(10'h3CC, m);
        wr(10'h338, 8'h00);
        wr(10'h338, 8'h01);
    endtask
endmodule // scs_host
`default_nettype wire

//--- test/tb.sv
// Bench: command timing, bandwidth choice, custom settling, bypass.
// Assumes the host model and shortened calibration and settle counts.
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ==========================================
    // Signals and hang guard
    // ==========================================
    logic clk_sys_i = 0, reset_n_i = 0, rx_c = 0, tx_c = 0, low = 0, wr;
    logic cal, rdy, rxs, txs, gs, d4;
    logic [2:0] bw;
    logic [7:0] rv, wd, band, ampl, v;
    logic [9:0] ad;
    logic [11:0] rate = 12'h000;
    int mismatches = 0, comparisons = 0, cyc = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
        if (++cyc == 6000) finish_test(1);
    scs_sequencer #(.CAL_CYCLES(20), .SETTLE_CYCLES(10)) dut_u (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .cmd_enter_receive_i(rx_c), .cmd_enter_transmit_i(tx_c),
        .data_rate_i(rate), .rf_band_low_i(low), .vco_band_cal_i(8'h5A),
        .vco_ampl_cal_i(8'hC3), .reg_addr_i(ad), .reg_wr_i(wr), .reg_wdata_i(wd),
        .reg_rdata_o(rv), .cal_run_o(cal), .synth_ready_o(rdy), .receive_state_o(rxs),
        .transmit_state_o(txs), .loop_bw_sel_o(bw), .gaussian_en_o(gs), .vco_div4_o(d4),
        .vco_band_o(band), .vco_ampl_o(ampl));
    scs_host h (.clk_sys_i(clk_sys_i), .reg_rdata_i(rv), .reg_addr_o(ad), .reg_wr_o(wr),
        .reg_wdata_o(wd));
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic finish_test(input int extra);
        mismatches += extra;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) mismatches++;
        if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
    endtask
    // Pulse a command, measure both phases, then judge the entry
    task automatic run(input logic r, input int c, input int s, input logic [2:0] b);
        int nc, ns;
        @(negedge clk_sys_i) {rx_c, tx_c} = {r, ~r};
        @(negedge clk_sys_i) {rx_c, tx_c} = 2'b00;
        for (nc = 0; cal === 1'b1 && nc < 999; nc++) @(negedge clk_sys_i);
        for (ns = 0; rdy !== 1'b1 && ns < 999; ns++) @(negedge clk_sys_i);
        chk("cal cycles", 16'(c), 16'(nc));
        chk("settle cycles", 16'(s), 16'(ns));
        chk("loop bw", 16'(b), 16'(bw));
        chk("direction", {14'h0, r, ~r}, {14'h0, rxs, txs});
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_rx();
        rate = 12'h960;
        run(1'b1, 20, 10, 3'h0);
        chk("div2", 16'h0000, {15'h0, d4});
        h.rd(10'h339, v);
        chk("status", 16'h0003, {8'h00, v});
        h.rd(10'h3DA, v);
        chk("band result", 16'h005A, {8'h00, v});
        h.rd(10'h3DB, v);
        chk("ampl result", 16'h00C3, {8'h00, v});
    endtask
    task automatic t_rates();
        logic [11:0] rt [11] = '{495, 496, 991, 992, 1295, 1296, 1791, 1792, 2399, 2400, 3000};
        logic [2:0] bt [11] = '{1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6};
        h.wr(10'h115, 8'h01);
        low = 1'b1;
        for (int i = 0; i < 11; i++)
        begin
            rate = rt[i];
            run(1'b0, 20, 10, bt[i]);
        end
    endtask
    task automatic t_ook();
        chk("gaussian", 16'h0001, {15'h0, gs});
        chk("div4", 16'h0001, {15'h0, d4});
        h.wr(10'h115, 8'h02);
        run(1'b0, 20, 10, 3'h7);
        chk("gaussian off", 16'h0000, {15'h0, gs});
    endtask
    task automatic t_custom();
        h.wr(10'h11A, 8'h08);
        h.wr(10'h13E, 8'h01);
        h.wr(10'h13F, 8'h00);
        run(1'b0, 20, 250, 3'h7);
        run(1'b1, 20, 500, 3'h0);
        h.wr(10'h11A, 8'h00);
    endtask
    task automatic t_bypass();
        h.arm(8'h11, 8'h22);
        run(1'b0, 0, 10, 3'h7);
        chk("band applied", 16'h1122, {band, ampl});
        h.rd(10'h339, v);
        chk("status bypass", 16'h0002, {8'h00, v});
    endtask
    initial
    begin
        repeat (6) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        t_rx();
        t_rates();
        t_ook();
        t_custom();
        t_bypass();
        finish_test(0);
    end
endmodule // tb
`default_nettype wire
